//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

// compare two values, count it, report a mismatch at once
`define chk(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
    import clkgen_ctrl_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic clk_sys, sys_rst, clk_en, reg_wr, reg_rd, reg_rd_valid;
    logic [7:0] reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data;
    logic rst_sync_pin_n, ref_select_pin, multi_pin_d, multi_pin_b;
    logic fsm_rst, ref_mux_sel, pin_mode, powerdown, global_output_gate;
    logic [3:0] channel_output_gate;
    logic config_busy, calib_busy, seq_done;
    int n_mismatch, comparisons, cycles, i, n;

    global_reset_and_input_select_ctrl #(.config_cycles(16), .calib_cycles(32)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .rst_sync_pin_n(rst_sync_pin_n), .ref_select_pin(ref_select_pin),
        .multi_pin_d(multi_pin_d), .multi_pin_b(multi_pin_b),
        .fsm_rst(fsm_rst), .ref_mux_sel(ref_mux_sel), .pin_mode(pin_mode),
        .powerdown(powerdown), .global_output_gate(global_output_gate),
        .channel_output_gate(channel_output_gate), .config_busy(config_busy),
        .calib_busy(calib_busy), .seq_done(seq_done)
    );

    // ************************************************************
    // clock and hang guard
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // a run far longer than the tests need counts as a failure
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ************************************************************
    // access tasks
    // ************************************************************
    // inputs move 1 ns after the rising edge
    task tick;
        @(posedge clk_sys);
        #1;
    endtask : tick

    task settle;
        repeat (6) tick();
    endtask : settle

    task wr(input logic [7:0] a, input logic [15:0] d);
        tick();
        reg_addr = a;
        reg_wr_data = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
    endtask : wr

    // read data and valid come one edge after the strobe
    task rd(input logic [7:0] a, input logic [15:0] exp);
        tick();
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        `chk(reg_rd_valid, 1'b1)
        `chk(reg_rd_data, exp)
    endtask : rd

    // count cycles of state machine reset over the next six cycles
    task count_rst(output int cnt);
        cnt = 0;
        repeat (6) begin
            tick();
            if (fsm_rst !== 1'b0) cnt++;
        end
    endtask : count_rst

    task test_done;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wr_data = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rst_sync_pin_n = 1'b1;
        ref_select_pin = 1'b0;
        multi_pin_d = 1'b1;
        multi_pin_b = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        // reset values, unmapped place
        rd(8'h01, 16'h6a32);
        rd(8'h00, 16'h0000);
        wr(8'h05, 16'hffff);
        rd(8'h05, 16'h0000);
        rd(8'h01, 16'h6a32);
        $display("test reset_values done");
        // reference mux source and override
        ref_select_pin = 1'b1;
        wr(8'h01, 16'h6832);
        settle();
        `chk(ref_mux_sel, 1'b1)
        ref_select_pin = 1'b0;
        settle();
        `chk(ref_mux_sel, 1'b0)
        wr(8'h01, 16'h6b32);
        settle();
        `chk(ref_mux_sel, 1'b1)
        ref_select_pin = 1'b1;
        wr(8'h01, 16'h6a32);
        settle();
        `chk(ref_mux_sel, 1'b0)
        $display("test ref_mux done");
        // serial mode ignores the pins, pin mode routes them
        multi_pin_d = 1'b0;
        multi_pin_b = 1'b0;
        settle();
        `chk({global_output_gate, channel_output_gate}, 5'h1f)
        `chk(pin_mode, 1'b0)
        wr(8'h00, 16'h0003);
        rd(8'h00, 16'h0003);
        settle();
        `chk(pin_mode, 1'b1)
        `chk(powerdown, 1'b1)
        wr(8'h00, 16'h0001);
        multi_pin_b = 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(8'h01, 16'h6802 | (16'(i + 4) << 4));
            settle();
            `chk({global_output_gate, channel_output_gate}, {1'b1, 4'hf & ~(4'h1 << i)})
        end
        multi_pin_b = 1'b0;
        settle();
        `chk({global_output_gate, channel_output_gate}, 5'h07)
        wr(8'h01, 16'h6827);
        multi_pin_d = 1'b1;
        settle();
        `chk({global_output_gate, channel_output_gate}, 5'h17)
        wr(8'h01, 16'h6825);
        settle();
        `chk({global_output_gate, channel_output_gate}, 5'h1d)
        multi_pin_b = 1'b1;
        $display("test routing done");
        // software reset pulse and sequencer restart
        for (i = 0; i < 200 && seq_done !== 1'b1; i++) tick();
        `chk(seq_done, 1'b1)
        wr(8'h00, 16'h0001);
        count_rst(n);
        `chk(n, 0)
        wr(8'h00, 16'h0005);
        count_rst(n);
        `chk(n, 1)
        `chk(config_busy, 1'b1)
        `chk(seq_done, 1'b0)
        rd(8'h00, 16'h0001);
        rd(8'h01, 16'h6825);
        repeat (20) tick();
        `chk(calib_busy, 1'b1)
        $display("test soft_reset done");
        // pin reset, full scope then state machines only
        wr(8'h01, 16'h6854);
        rst_sync_pin_n = 1'b0;
        repeat (8) tick();
        `chk(fsm_rst, 1'b1)
        rst_sync_pin_n = 1'b1;
        settle();
        rd(8'h01, 16'h6a32);
        rd(8'h00, 16'h0000);
        wr(8'h00, 16'h0009);
        wr(8'h01, 16'h6854);
        rst_sync_pin_n = 1'b0;
        repeat (8) tick();
        `chk(fsm_rst, 1'b1)
        rst_sync_pin_n = 1'b1;
        settle();
        rd(8'h00, 16'h0009);
        rd(8'h01, 16'h6854);
        $display("test pin_reset done");
        test_done();
    end
endmodule : tb

`default_nettype wire

//--- rtl/clkgen_ctrl_pkg.sv
`default_nettype none

package clkgen_ctrl_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] global_control_addr = 8'h00;
    localparam logic [7:0] input_select_config_addr = 8'h01;

    // global_control bit positions
    localparam int mode_bit = 0;
    localparam int powerdown_bit = 1;
    localparam int soft_reset_bit = 2;
    localparam int pin_reset_scope_bit = 3;

    // input_select_config field layout, msb first
    typedef struct packed {
        logic [5:0] reserved;
        logic ref_src;
        logic ref_override;
        logic [3:0] pin_d_input_route;
        logic [3:0] pin_b_input_route;
    } input_select_s;

    typedef struct packed {
        logic pin_reset_scope;
        logic powerdown;
        logic mode;
    } global_ctrl_s;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam input_select_s input_select_reset = 16'h6a32;
    localparam global_ctrl_s global_ctrl_reset = 3'h0;

    // route codes
    localparam logic [3:0] route_global_oe = 4'h2;
    localparam logic [3:0] route_channel_one = 4'h4;

    // pin vector positions after the input synchroniser
    localparam int pin_rst_idx = 0;
    localparam int pin_ref_idx = 1;
    localparam int pin_d_idx = 2;
    localparam int pin_b_idx = 3;

    // ************************************************************
    // sequencer
    // ************************************************************
    typedef enum logic [1:0] {
        seq_config = 2'b00,
        seq_calib = 2'b01,
        seq_ready = 2'b10
    } seq_state_e;

    localparam int config_cycles_default = 16;
    localparam int calib_cycles_default = 32;

endpackage : clkgen_ctrl_pkg

`default_nettype wire

//--- rtl/global_reset_and_input_select_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module global_reset_and_input_select_ctrl
    import clkgen_ctrl_pkg::*;
#(
    parameter int config_cycles = clkgen_ctrl_pkg::config_cycles_default,
    parameter int calib_cycles = clkgen_ctrl_pkg::calib_cycles_default
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    // device pins
    input wire logic rst_sync_pin_n,
    input wire logic ref_select_pin,
    input wire logic multi_pin_d,
    input wire logic multi_pin_b,
    // controls to the rest of the device
    output logic fsm_rst,
    output logic ref_mux_sel,
    output logic pin_mode,
    output logic powerdown,
    output logic global_output_gate,
    output logic [3:0] channel_output_gate,
    output logic config_busy,
    output logic calib_busy,
    output logic seq_done
);
    import clkgen_ctrl_pkg::*;

    // gate value: pin level when a route field selects the code, else enabled
    function automatic logic route_gate(input logic [3:0] rd, input logic [3:0] rb,
                                        input logic [3:0] code, input logic pd,
                                        input logic pb);
        logic g;
        g = 1'b1;
        if (rd == code) begin
            g = pd;
        end else if (rb == code) begin
            g = pb;
        end
        return g;
    endfunction : route_gate

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    logic [3:0] pin_s1, pin_s2, pin_s3, pin_filt;
    logic [3:0] next_pin_filt;
    logic [3:0] pin_raw;
    logic pin_rst_act;

    // a change counts once the second and third stages agree
    always_comb begin
        pin_raw = {multi_pin_b, multi_pin_d, ref_select_pin, ~rst_sync_pin_n};
        next_pin_filt = (pin_s2 & pin_s3) | (pin_filt & (pin_s2 | pin_s3));
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
            pin_filt <= 4'h0;
        end else if (clk_en) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_filt <= next_pin_filt;
        end
    end

    assign pin_rst_act = pin_filt[pin_rst_idx];

    // ************************************************************
    // registers
    // ************************************************************
    input_select_s isc, next_isc;
    global_ctrl_s gctl, next_gctl;
    logic swrst_pulse, next_swrst_pulse;
    logic [15:0] next_rd_data;

    // write decode, pin hard reset and the self clearing reset bit
    always_comb begin
        next_isc = isc;
        next_gctl = gctl;
        next_swrst_pulse = 1'b0;
        if (pin_rst_act && !gctl.pin_reset_scope) begin
            next_isc = input_select_reset;
            next_gctl = global_ctrl_reset;
        end else if (reg_wr) begin
            if (reg_addr == global_control_addr) begin
                next_gctl.mode = reg_wr_data[mode_bit];
                next_gctl.powerdown = reg_wr_data[powerdown_bit];
                next_gctl.pin_reset_scope = reg_wr_data[pin_reset_scope_bit];
                next_swrst_pulse = reg_wr_data[soft_reset_bit];
            end else if (reg_addr == input_select_config_addr) begin
                next_isc = reg_wr_data;
            end
        end
        next_rd_data = 16'h0000;
        if (reg_addr == global_control_addr) begin
            // soft reset bit is never stored and reads 0
            next_rd_data[mode_bit] = gctl.mode;
            next_rd_data[powerdown_bit] = gctl.powerdown;
            next_rd_data[pin_reset_scope_bit] = gctl.pin_reset_scope;
        end else if (reg_addr == input_select_config_addr) begin
            next_rd_data = isc;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            isc <= input_select_reset;
            gctl <= global_ctrl_reset;
            swrst_pulse <= 1'b0;
            reg_rd_data <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end else if (clk_en) begin
            isc <= next_isc;
            gctl <= next_gctl;
            swrst_pulse <= next_swrst_pulse;
            reg_rd_data <= reg_rd ? next_rd_data : reg_rd_data;
            reg_rd_valid <= reg_rd;
        end
    end

    // ************************************************************
    // configuration and calibration sequencer
    // ************************************************************
    seq_state_e seq_state, next_seq_state;
    logic [15:0] seq_cnt, next_seq_cnt;
    logic logic_rst;

    // pin reset (either scope) and the soft reset pulse both restart it
    assign logic_rst = pin_rst_act | swrst_pulse;

    always_comb begin
        next_seq_state = seq_state;
        next_seq_cnt = seq_cnt + 16'h0001;
        if (logic_rst) begin
            next_seq_state = seq_config;
            next_seq_cnt = 16'h0000;
        end else begin
            case (seq_state)
                seq_config: begin
                    if (seq_cnt == 16'(config_cycles - 1)) begin
                        next_seq_state = seq_calib;
                        next_seq_cnt = 16'h0000;
                    end
                end
                seq_calib: begin
                    if (seq_cnt == 16'(calib_cycles - 1)) begin
                        next_seq_state = seq_ready;
                        next_seq_cnt = 16'h0000;
                    end
                end
                seq_ready: begin
                    next_seq_cnt = 16'h0000;
                end
                default: begin
                    next_seq_state = seq_config;
                    next_seq_cnt = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            seq_state <= seq_config;
            seq_cnt <= 16'h0000;
        end else if (clk_en) begin
            seq_state <= next_seq_state;
            seq_cnt <= next_seq_cnt;
        end
    end

    // ************************************************************
    // output stage
    // ************************************************************
    logic [3:0] chan_gate;
    logic next_global_gate, next_ref_sel;

    // one enable per channel, only in pin mode
    for (genvar i = 0; i < 4; i++) begin : g_chan
        assign chan_gate[i] = !gctl.mode ? 1'b1 : route_gate(isc.pin_d_input_route,
            isc.pin_b_input_route, route_channel_one + 4'(i), pin_filt[pin_d_idx],
            pin_filt[pin_b_idx]);
    end

    always_comb begin
        next_ref_sel = isc.ref_src ? isc.ref_override : pin_filt[pin_ref_idx];
        next_global_gate = !gctl.mode ? 1'b1 : route_gate(isc.pin_d_input_route,
            isc.pin_b_input_route, route_global_oe, pin_filt[pin_d_idx],
            pin_filt[pin_b_idx]);
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fsm_rst <= 1'b1;
            ref_mux_sel <= 1'b0;
            pin_mode <= 1'b0;
            powerdown <= 1'b0;
            global_output_gate <= 1'b1;
            channel_output_gate <= 4'hf;
            config_busy <= 1'b0;
            calib_busy <= 1'b0;
            seq_done <= 1'b0;
        end else if (clk_en) begin
            fsm_rst <= logic_rst;
            ref_mux_sel <= next_ref_sel;
            pin_mode <= gctl.mode;
            powerdown <= gctl.powerdown;
            global_output_gate <= next_global_gate;
            channel_output_gate <= chan_gate;
            config_busy <= next_seq_state == seq_config;
            calib_busy <= next_seq_state == seq_calib;
            seq_done <= next_seq_state == seq_ready;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_swrst_write;
        clk_en && reg_wr && reg_addr == global_control_addr && reg_wr_data[soft_reset_bit]
            && !(pin_rst_act && !gctl.pin_reset_scope);
    endsequence

    sequence s_one_pulse;
        swrst_pulse ##1 (!swrst_pulse || !$past(clk_en) || $past(reg_wr
            && reg_addr == global_control_addr && reg_wr_data[soft_reset_bit]));
    endsequence

    a_swrst_single_pulse: assert property (s_swrst_write |=> s_one_pulse)
        else $error("soft reset pulse not one cycle");
    a_swrst_reads_zero: assert property (clk_en && reg_rd && reg_addr == 8'h00
        |=> !reg_rd_data[2])
        else $error("soft reset bit read back as 1");
    a_hard_pin_reset: assert property (clk_en && pin_rst_act && !gctl.pin_reset_scope
        |=> isc == 16'h6a32 && !gctl.mode)
        else $error("hard pin reset did not restore registers");
    a_soft_pin_keeps: assert property (clk_en && pin_rst_act && gctl.pin_reset_scope && !reg_wr
        |=> $stable(isc) && fsm_rst)
        else $error("soft pin reset changed registers");
    a_seq_restart: assert property (clk_en && swrst_pulse
        |=> seq_state == seq_config && seq_cnt == 16'h0000 && config_busy)
        else $error("soft reset did not restart configuration");
    a_ref_from_pin: assert property (clk_en && !isc.ref_src
        |=> ref_mux_sel == $past(pin_filt[1]))
        else $error("reference select not following pin");
    a_ref_override: assert property (clk_en && isc.ref_src
        |=> ref_mux_sel == $past(isc.ref_override))
        else $error("reference select not following override");
    a_serial_mode_open: assert property (clk_en && !gctl.mode
        |=> global_output_gate && channel_output_gate == 4'hf)
        else $error("enables gated in serial mode");
    a_route_d_chan: assert property (clk_en && gctl.mode && isc.pin_d_input_route == 4'h5
        |=> channel_output_gate[1] == $past(pin_filt[2]))
        else $error("pin d not routed to channel two");
    a_route_b_global: assert property (clk_en && gctl.mode && isc.pin_b_input_route == 4'h2
        && isc.pin_d_input_route != 4'h2 |=> global_output_gate == $past(pin_filt[3]))
        else $error("pin b not routed to global enable");

endmodule : global_reset_and_input_select_ctrl

`default_nettype wire
